/* File: rtl/bridge_pkg.sv */
// constants and carrier types for the bridge io window and secondary status logic
package bridge_pkg;

  // configuration byte offsets
  localparam logic [7:0] OFS_IO_BOTTOM       = 8'h1c;
  localparam logic [7:0] OFS_IO_TOP          = 8'h1d;
  localparam logic [7:0] OFS_SEC_STATUS      = 8'h1e;
  localparam logic [7:0] OFS_IO_BOTTOM_UPPER = 8'h30;
  localparam logic [7:0] OFS_IO_TOP_UPPER    = 8'h32;

  // field positions inside the io window bytes
  localparam int         IO_FIELD_LSB = 4;
  localparam int         IO_KIND_LSB  = 0;
  localparam logic [3:0] IO_KIND_32   = 4'h1;

  // low address bits assumed for the window edges
  localparam logic [11:0] IO_BOTTOM_LOW = 12'h000;
  localparam logic [11:0] IO_TOP_LOW    = 12'hfff;

  // reset values
  localparam logic [3:0]  IO_NIBBLE_RESET = 4'h0;
  localparam logic [15:0] IO_UPPER_RESET  = 16'h0000;
  localparam logic [15:0] STATUS_RESET    = 16'h02a0;

  // secondary status bit positions
  localparam int ST_DETECTED_PARITY = 15;
  localparam int ST_RECEIVED_SYSTEM = 14;
  localparam int ST_GOT_MASTER_ABT  = 13;
  localparam int ST_GOT_TARGET_ABT  = 12;
  localparam int ST_SENT_TARGET_ABT = 11;
  localparam int ST_MASTER_PARITY   = 8;

  // status masks: sticky bits and constant bits
  localparam logic [15:0] STATUS_STICKY_MASK = 16'hf900;
  localparam logic [15:0] STATUS_FIXED_BITS  = 16'h02a0;

  // one configuration access, dword addressed by addr[7:2]
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } cfg_req_t;

  // one-cycle event pulses from the secondary bus interface
  typedef struct packed {
    logic addr_attr_err_as_target;
    logic write_data_err_as_target;
    logic read_data_err_as_master;
    logic serr_seen;
    logic master_abort_seen;
    logic target_abort_received;
    logic target_abort_signaled;
    logic bus_master_active;
    logic perr_driven_on_read;
    logic perr_seen_on_write;
  } sec_events_t;

  // compose a 32-bit io window edge address
  function automatic logic [31:0] window_addr(input logic [15:0] upper,
                                              input logic [3:0]  nibble,
                                              input logic [11:0] low);
    window_addr = {upper, nibble, low};
  endfunction : window_addr

endpackage : bridge_pkg

/* File: rtl/io_window_match.sv */
// io forwarding window compare with registered decision
`timescale 1ns/100ps
module io_window_match (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        req_valid,
  input  wire logic [31:0] req_addr,
  input  wire logic [31:0] bottom,
  input  wire logic [31:0] top,
  output logic             fwd_valid,
  output logic             fwd
);

  logic in_window;

  // inclusive on both edges; bottom above top gives an empty window
  assign in_window = (req_addr >= bottom) && (req_addr <= top);

  // decision lands one cycle after the request
  always_ff @(posedge clk) begin
    if (rst) begin
      fwd_valid <= 1'b0;
      fwd       <= 1'b0;
    end else if (ce) begin
      fwd_valid <= req_valid;
      fwd       <= req_valid && in_window;
    end
  end

  AST_FWD_DECISION: assert property (@(posedge clk) disable iff (rst)
    ce && req_valid |=> fwd_valid && (fwd == $past(in_window)))
    else $error("io forward decision wrong");

endmodule : io_window_match

/* File: rtl/bridge_io_limit_secondary_status.sv */
// io window registers and secondary status register of the bridge
// Overview of operation
// - io top field bits 7:4, address 15:12
// - top address low twelve bits all ones
// - top address bits 31:16 from offset 32h
// - io top bits 3:0 read 1h
// - window decides io forwarding
// - bit 15 set on three fault cases
// - bit 15 ignores parity response enable
// - bit 14 set on seen SERR
// - bit 13 set on master abort
// - bit 12 set on received target abort
// - bit 11 set on signaled target abort
// - bits 10:9 read 01b
// - bit 8 needs master, enable, PERR
// - bit 7 reads 1
// - bit 5 reads 1
// - bits 6, 4:0 read zero
// - bottom from base field, low bits zero
`timescale 1ns/100ps
module bridge_io_limit_secondary_status (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     ce,
  input  wire bridge_pkg::cfg_req_t     cfg_req,
  output logic [31:0]                   cfg_rdata,
  output logic                          cfg_rvalid,
  input  wire bridge_pkg::sec_events_t  sec_events,
  input  wire logic                     parity_response_enable,
  input  wire logic                     io_req_valid,
  input  wire logic [31:0]              io_req_addr,
  output logic                          io_fwd_valid,
  output logic                          io_fwd
);

  logic [3:0]  io_bottom_addr_bits;
  logic [3:0]  io_top_addr_bits;
  logic [15:0] io_bottom_upper;
  logic [15:0] io_top_upper;
  logic [15:0] secondary_bus_status;
  logic [15:0] next_secondary_bus_status;
  logic [15:0] status_set;
  logic [15:0] status_clear;
  logic [7:0]  io_bottom_byte;
  logic [7:0]  io_window_upper_limit;
  logic [31:0] window_bottom;
  logic [31:0] window_top;
  logic [31:0] next_rdata;
  logic        hit_io_dword;
  logic        hit_upper_dword;
  logic        wr_io;
  logic        wr_upper;
  logic        rd_io;

  // dword decode; only the two dwords holding our bytes answer
  assign hit_io_dword    = cfg_req.addr[7:2] == bridge_pkg::OFS_IO_BOTTOM[7:2];
  assign hit_upper_dword = cfg_req.addr[7:2] == bridge_pkg::OFS_IO_BOTTOM_UPPER[7:2];
  assign wr_io           = ce && cfg_req.wr && hit_io_dword;
  assign wr_upper        = ce && cfg_req.wr && hit_upper_dword;
  assign rd_io           = ce && cfg_req.rd && hit_io_dword;

  // byte views with the constant io kind in the low nibble
  assign io_bottom_byte        = {io_bottom_addr_bits, bridge_pkg::IO_KIND_32};
  assign io_window_upper_limit = {io_top_addr_bits, bridge_pkg::IO_KIND_32};

  // window edges: bottom ends in 000h, top ends in fffh
  assign window_bottom = bridge_pkg::window_addr(io_bottom_upper, io_bottom_addr_bits,
                                                 bridge_pkg::IO_BOTTOM_LOW);
  assign window_top    = bridge_pkg::window_addr(io_top_upper, io_top_addr_bits,
                                                 bridge_pkg::IO_TOP_LOW);

  // io window nibbles, written through byte lanes 0 and 1
  always_ff @(posedge clk) begin
    if (rst) begin
      io_bottom_addr_bits <= bridge_pkg::IO_NIBBLE_RESET;
      io_top_addr_bits    <= bridge_pkg::IO_NIBBLE_RESET;
    end else if (wr_io) begin
      if (cfg_req.be[0]) begin
        io_bottom_addr_bits <= cfg_req.wdata[7:4];
      end
      if (cfg_req.be[1]) begin
        io_top_addr_bits <= cfg_req.wdata[15:12];
      end
    end
  end

  // upper halves of the window at 30h and 32h
  always_ff @(posedge clk) begin
    if (rst) begin
      io_bottom_upper <= bridge_pkg::IO_UPPER_RESET;
      io_top_upper    <= bridge_pkg::IO_UPPER_RESET;
    end else if (wr_upper) begin
      if (cfg_req.be[0]) begin
        io_bottom_upper[7:0] <= cfg_req.wdata[7:0];
      end
      if (cfg_req.be[1]) begin
        io_bottom_upper[15:8] <= cfg_req.wdata[15:8];
      end
      if (cfg_req.be[2]) begin
        io_top_upper[7:0] <= cfg_req.wdata[23:16];
      end
      if (cfg_req.be[3]) begin
        io_top_upper[15:8] <= cfg_req.wdata[31:24];
      end
    end
  end

  // status event set vector; parity enable gates only bit 8
  always_comb begin
    status_set = 16'h0000;
    status_set[bridge_pkg::ST_DETECTED_PARITY] = sec_events.addr_attr_err_as_target
                                               | sec_events.write_data_err_as_target
                                               | sec_events.read_data_err_as_master;
    status_set[bridge_pkg::ST_RECEIVED_SYSTEM] = sec_events.serr_seen;
    status_set[bridge_pkg::ST_GOT_MASTER_ABT]  = sec_events.master_abort_seen;
    status_set[bridge_pkg::ST_GOT_TARGET_ABT]  = sec_events.target_abort_received;
    status_set[bridge_pkg::ST_SENT_TARGET_ABT] = sec_events.target_abort_signaled;
    status_set[bridge_pkg::ST_MASTER_PARITY]   = sec_events.bus_master_active
                                               & parity_response_enable
                                               & (sec_events.perr_driven_on_read
                                                  | sec_events.perr_seen_on_write);
  end

  // write-one-to-clear mask from byte lanes 2 and 3
  always_comb begin
    status_clear = 16'h0000;
    if (wr_io) begin
      if (cfg_req.be[2]) begin
        status_clear[7:0] = cfg_req.wdata[23:16];
      end
      if (cfg_req.be[3]) begin
        status_clear[15:8] = cfg_req.wdata[31:24];
      end
    end
  end

  // set wins over clear so an event in the clearing cycle survives
  always_comb begin
    next_secondary_bus_status = (((secondary_bus_status & ~status_clear) | status_set)
                                 & bridge_pkg::STATUS_STICKY_MASK)
                                | bridge_pkg::STATUS_FIXED_BITS;
  end

  // secondary status register
  always_ff @(posedge clk) begin
    if (rst) begin
      secondary_bus_status <= bridge_pkg::STATUS_RESET;
    end else if (ce) begin
      secondary_bus_status <= next_secondary_bus_status;
    end
  end

  // read mux; unmapped dwords read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (hit_io_dword) begin
      next_rdata = {secondary_bus_status, io_window_upper_limit, io_bottom_byte};
    end else if (hit_upper_dword) begin
      next_rdata = {io_top_upper, io_bottom_upper};
    end
  end

  // read data registered, valid one cycle after the request
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_rdata  <= 32'h0000_0000;
      cfg_rvalid <= 1'b0;
    end else if (ce) begin
      cfg_rvalid <= cfg_req.rd;
      if (cfg_req.rd) begin
        cfg_rdata <= next_rdata;
      end
    end
  end

  // forwarding decision against the programmed window
  io_window_match io_window_match_inst (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .req_valid (io_req_valid),
    .req_addr  (io_req_addr),
    .bottom    (window_bottom),
    .top       (window_top),
    .fwd_valid (io_fwd_valid),
    .fwd       (io_fwd)
  );

  AST_TOP_NIBBLE_WRITE: assert property (@(posedge clk) disable iff (rst)
    wr_io && cfg_req.be[1] |=> io_top_addr_bits == $past(cfg_req.wdata[15:12]))
    else $error("io top field not written");

  AST_TOP_ADDR_FORM: assert property (@(posedge clk) disable iff (rst)
    window_top[11:0] == 12'hfff && window_top[15:12] == io_top_addr_bits)
    else $error("io top address low bits wrong");

  AST_TOP_UPPER_READ: assert property (@(posedge clk) disable iff (rst)
    ce && cfg_req.rd && hit_upper_dword |=> cfg_rdata[31:16] == $past(io_top_upper))
    else $error("io top upper half mismatch");

  AST_IO_KIND_READ: assert property (@(posedge clk) disable iff (rst)
    rd_io |=> cfg_rdata[11:8] == 4'h1 && cfg_rdata[3:0] == 4'h1 && cfg_rvalid)
    else $error("io kind field not 1h");

  AST_PARITY_SET: assert property (@(posedge clk) disable iff (rst)
    ce && (sec_events.addr_attr_err_as_target || sec_events.write_data_err_as_target
           || sec_events.read_data_err_as_master)
    |=> secondary_bus_status[15])
    else $error("detected parity bit not set");

  AST_PARITY_NO_ENABLE: assert property (@(posedge clk) disable iff (rst)
    ce && !parity_response_enable && sec_events.read_data_err_as_master
    |=> secondary_bus_status[15])
    else $error("detected parity bit gated by enable");

  AST_SERR_SET: assert property (@(posedge clk) disable iff (rst)
    ce && sec_events.serr_seen |=> secondary_bus_status[14])
    else $error("system fault bit not set");

  AST_GOT_MASTER_ABORT_SET: assert property (@(posedge clk) disable iff (rst)
    ce && sec_events.master_abort_seen |=> secondary_bus_status[13])
    else $error("master abort bit not set");

  AST_TABORT_RX_SET: assert property (@(posedge clk) disable iff (rst)
    ce && sec_events.target_abort_received |=> secondary_bus_status[12])
    else $error("received target abort bit not set");

  AST_TABORT_TX_SET: assert property (@(posedge clk) disable iff (rst)
    ce && sec_events.target_abort_signaled |=> secondary_bus_status[11])
    else $error("signaled target abort bit not set");

  AST_FIXED_BITS_READ: assert property (@(posedge clk) disable iff (rst)
    rd_io |=> cfg_rdata[26:25] == 2'b01 && cfg_rdata[23] && cfg_rdata[21]
              && !cfg_rdata[22] && cfg_rdata[20:16] == 5'b00000)
    else $error("constant status bits wrong");

  AST_MASTER_PARITY_CAUSE: assert property (@(posedge clk) disable iff (rst)
    $rose(secondary_bus_status[8])
    |-> $past(sec_events.bus_master_active && parity_response_enable
              && (sec_events.perr_driven_on_read || sec_events.perr_seen_on_write)))
    else $error("master parity bit set without cause");

  AST_CONST_STATUS: assert property (@(posedge clk) disable iff (rst)
    secondary_bus_status[10:0] == 11'h2a0 || secondary_bus_status[10:0] == 11'h3a0)
    else $error("status constant bits drifted");

  AST_STICKY_HOLD: assert property (@(posedge clk) disable iff (rst)
    secondary_bus_status[14] && !(wr_io && cfg_req.be[3] && cfg_req.wdata[30])
    |=> secondary_bus_status[14])
    else $error("sticky bit lost without clear");

  AST_STICKY_CLEAR: assert property (@(posedge clk) disable iff (rst)
    wr_io && cfg_req.be[3] && cfg_req.wdata[29] && !sec_events.master_abort_seen
    |=> !secondary_bus_status[13])
    else $error("sticky bit not cleared by one");

  AST_BOTTOM_FORM: assert property (@(posedge clk) disable iff (rst)
    window_bottom[11:0] == 12'h000 && window_bottom[15:12] == io_bottom_addr_bits)
    else $error("io bottom address form wrong");

  // window registers hold unless written, and take the value written
  AST_TOP_NIBBLE_HOLD: assert property (@(posedge clk) disable iff (rst)
    !(wr_io && cfg_req.be[1]) |=> io_top_addr_bits == $past(io_top_addr_bits))
    else $error("io top field changed without a write");

  AST_BOTTOM_NIBBLE_WRITE: assert property (@(posedge clk) disable iff (rst)
    wr_io && cfg_req.be[0] |=> io_bottom_addr_bits == $past(cfg_req.wdata[7:4]))
    else $error("io bottom field not written");

  AST_TOP_UPPER_WRITE: assert property (@(posedge clk) disable iff (rst)
    wr_upper && cfg_req.be[2] && cfg_req.be[3]
    |=> io_top_upper == $past(cfg_req.wdata[31:16]))
    else $error("io top upper half not written");

  AST_TOP_UPPER_HOLD: assert property (@(posedge clk) disable iff (rst)
    !wr_upper |=> io_top_upper == $past(io_top_upper))
    else $error("io top upper half changed without a write");

  // the last byte of the window must still forward; a lost fffh end is easy to miss
  AST_FWD_AT_TOP: assert property (@(posedge clk) disable iff (rst)
    ce && io_req_valid && io_req_addr == window_top && window_bottom <= window_top
    |=> io_fwd_valid && io_fwd)
    else $error("last byte of the io window not forwarded");

  AST_FWD_ABOVE_TOP: assert property (@(posedge clk) disable iff (rst)
    ce && io_req_valid && io_req_addr > window_top |=> io_fwd_valid && !io_fwd)
    else $error("address above the io window forwarded");

  AST_FWD_BELOW_BOTTOM: assert property (@(posedge clk) disable iff (rst)
    ce && io_req_valid && io_req_addr < window_bottom |=> io_fwd_valid && !io_fwd)
    else $error("address below the io window forwarded");

  AST_FWD_NO_REQ: assert property (@(posedge clk) disable iff (rst)
    ce && !io_req_valid |=> !io_fwd_valid && !io_fwd)
    else $error("forward decision without a request");

  // status bits rise only on their own cause, and a set beats a clear
  AST_PARITY_CAUSE: assert property (@(posedge clk) disable iff (rst)
    $rose(secondary_bus_status[15])
    |-> $past(sec_events.addr_attr_err_as_target || sec_events.write_data_err_as_target
              || sec_events.read_data_err_as_master))
    else $error("detected parity bit set without cause");

  AST_SERR_CAUSE: assert property (@(posedge clk) disable iff (rst)
    $rose(secondary_bus_status[14]) |-> $past(sec_events.serr_seen))
    else $error("system fault bit set without cause");

  AST_GOT_MASTER_ABORT_CAUSE: assert property (@(posedge clk) disable iff (rst)
    $rose(secondary_bus_status[13]) |-> $past(sec_events.master_abort_seen))
    else $error("master abort bit set without cause");

  AST_TABORT_RX_CAUSE: assert property (@(posedge clk) disable iff (rst)
    $rose(secondary_bus_status[12]) |-> $past(sec_events.target_abort_received))
    else $error("received target abort bit set without cause");

  AST_TABORT_TX_CAUSE: assert property (@(posedge clk) disable iff (rst)
    $rose(secondary_bus_status[11]) |-> $past(sec_events.target_abort_signaled))
    else $error("signaled target abort bit set without cause");

  AST_SET_BEATS_CLEAR: assert property (@(posedge clk) disable iff (rst)
    wr_io && cfg_req.be[3] && cfg_req.wdata[30] && sec_events.serr_seen
    |=> secondary_bus_status[14])
    else $error("event lost to a clear in the same cycle");

  AST_ZERO_WRITE_KEEPS: assert property (@(posedge clk) disable iff (rst)
    wr_io && cfg_req.be[3] && !cfg_req.wdata[27] && secondary_bus_status[11]
    |=> secondary_bus_status[11])
    else $error("sticky bit cleared by a zero");

  AST_RESERVED_WRITE_IGNORED: assert property (@(posedge clk) disable iff (rst)
    wr_io && cfg_req.be[2] && cfg_req.wdata[22] |=> !secondary_bus_status[6])
    else $error("reserved status bit took a write");

  AST_MASTER_PARITY_SET: assert property (@(posedge clk) disable iff (rst)
    ce && sec_events.bus_master_active && parity_response_enable
    && (sec_events.perr_driven_on_read || sec_events.perr_seen_on_write)
    |=> secondary_bus_status[8])
    else $error("master parity bit not set");

  AST_MASTER_PARITY_GATED: assert property (@(posedge clk) disable iff (rst)
    ce && !parity_response_enable && !secondary_bus_status[8] |=> !secondary_bus_status[8])
    else $error("master parity bit set with response disabled");

endmodule : bridge_io_limit_secondary_status

/* File: test/sec_bus_model.sv */
// behavioural secondary bus side that raises one event pulse on command
`timescale 1ns/100ps
module sec_bus_model (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  fire,
  input  wire logic [3:0]            kind,
  output bridge_pkg::sec_events_t    sec_events
);
  // one-cycle pulse per command; idle lines sit at zero, never repeat old values
  always_ff @(posedge clk) begin
    sec_events <= '0;
    if (!rst && fire) begin
      case (kind)
        4'h0: sec_events.addr_attr_err_as_target <= 1'b1;
        4'h1: sec_events.write_data_err_as_target <= 1'b1;
        4'h2: sec_events.read_data_err_as_master <= 1'b1;
        4'h3: sec_events.serr_seen <= 1'b1;
        4'h4: sec_events.master_abort_seen <= 1'b1;
        4'h5: sec_events.target_abort_received <= 1'b1;
        4'h6: sec_events.target_abort_signaled <= 1'b1;
        // parity fault with the bridge owning the bus
        4'h7: sec_events <= '{bus_master_active: 1'b1, perr_driven_on_read: 1'b1, default: 1'b0};
        4'h8: sec_events <= '{bus_master_active: 1'b1, perr_seen_on_write: 1'b1, default: 1'b0};
        // same fault without ownership, must not count as a master fault
        default: sec_events.perr_driven_on_read <= 1'b1;
      endcase
    end
  end
endmodule : sec_bus_model

/* File: test/tb_top.sv */
// self-checking bench for the io window and secondary status registers
`timescale 1ns/100ps
module tb_top;
  logic                    clk = 1'b0;
  logic                    rst = 1'b1;
  logic                    ce = 1'b1;
  bridge_pkg::cfg_req_t    cfg_req = '0;
  logic [31:0]             cfg_rdata;
  logic                    cfg_rvalid;
  bridge_pkg::sec_events_t sec_events;
  logic                    parity_response_enable = 1'b1;
  logic                    io_req_valid = 1'b0;
  logic [31:0]             io_req_addr = 32'h0000_0000;
  logic                    io_fwd_valid;
  logic                    io_fwd;
  logic                    fire = 1'b0;
  logic [3:0]              kind = 4'h0;
  int                      errors = 0;
  int                      samples_checked = 0;
  logic [31:0]             rd;
  // event table: model command, enable level, expected sticky bit
  logic [3:0]  ev_kind [12] = '{4'h0, 4'h1, 4'h2, 4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8,
                                4'h7, 4'h9};
  logic        ev_pre [12] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1,
                               1'b0, 1'b1};
  logic [15:0] ev_bit [12] = '{16'h8000, 16'h8000, 16'h8000, 16'h8000, 16'h4000, 16'h2000,
                               16'h1000, 16'h0800, 16'h0100, 16'h0100, 16'h0000, 16'h0000};

  always #5 clk = ~clk;

  bridge_io_limit_secondary_status bridge_io_limit_secondary_status_inst (
    .clk(clk), .rst(rst), .ce(ce), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .sec_events(sec_events),
    .parity_response_enable(parity_response_enable), .io_req_valid(io_req_valid),
    .io_req_addr(io_req_addr), .io_fwd_valid(io_fwd_valid), .io_fwd(io_fwd));

  sec_bus_model sec_bus_model_inst (
    .clk(clk), .rst(rst), .fire(fire), .kind(kind), .sec_events(sec_events));

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // single write strobe, released at the next edge
  task automatic cfg_write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clk);
    cfg_req <= '{rd: 1'b0, wr: 1'b1, addr: a, be: be, wdata: d};
    @(posedge clk);
    cfg_req <= '0;
  endtask : cfg_write

  // answer comes exactly one cycle after the read edge
  task automatic cfg_read(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    cfg_req <= '{rd: 1'b1, wr: 1'b0, addr: a, be: 4'h0, wdata: 32'h0000_0000};
    @(posedge clk);
    cfg_req <= '0;
    #1;
    check("cfg_rvalid", 32'h0000_0001, {31'h0, cfg_rvalid});
    check("cfg_rdata", exp, cfg_rdata);
  endtask : cfg_read

  task automatic raise(input logic [3:0] k, input logic pre);
    @(posedge clk);
    fire <= 1'b1;
    kind <= k;
    parity_response_enable <= pre;
    @(posedge clk);
    fire <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : raise

  task automatic io_probe(input logic [31:0] a, input logic exp);
    @(posedge clk);
    io_req_valid <= 1'b1;
    io_req_addr <= a;
    @(posedge clk);
    io_req_valid <= 1'b0;
    #1;
    check("io_fwd_valid", 32'h0000_0001, {31'h0, io_fwd_valid});
    check("io_fwd", {31'h0, exp}, {31'h0, io_fwd});
  endtask : io_probe

  task automatic summarize;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  // watchdog sized well above the few hundred cycles the sequence needs
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    summarize();
  end

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    // reset image: both window bytes 01h, status 02a0h
    cfg_read(8'h1c, 32'h02a0_0101);
    cfg_read(8'h30, 32'h0000_0000);
    // all ones everywhere: only the window nibbles may take them
    cfg_write(8'h1c, 4'hf, 32'hffff_ffff);
    cfg_read(8'h1c, 32'h02a0_f1f1);
    // unmapped dword reads zero and ignores writes
    cfg_write(8'h40, 4'hf, 32'hffff_ffff);
    cfg_read(8'h40, 32'h0000_0000);
    // window 0001_2000 .. 0001_3fff
    cfg_write(8'h30, 4'hf, 32'h0001_0001);
    cfg_write(8'h1c, 4'h3, 32'h0000_3020);
    cfg_read(8'h30, 32'h0001_0001);
    cfg_read(8'h1c, 32'h02a0_3121);
    io_probe(32'h0001_2000, 1'b1);
    io_probe(32'h0001_1fff, 1'b0);
    io_probe(32'h0001_3fff, 1'b1);
    io_probe(32'h0001_4000, 1'b0);
    io_probe(32'h0000_3000, 1'b0);
    // top above limit upper half moves the end of the window
    cfg_write(8'h30, 4'hc, 32'h0002_0000);
    io_probe(32'h0002_3fff, 1'b1);
    // each event row sets its expected bit (none for the last two rows), survives a zero write, clears on a one
    for (int i = 0; i < 12; i++) begin
      raise(ev_kind[i], ev_pre[i]);
      cfg_read(8'h1c, {16'h02a0 | ev_bit[i], 16'h3121});
      cfg_write(8'h1c, 4'hc, 32'h0000_0000);
      cfg_read(8'h1c, {16'h02a0 | ev_bit[i], 16'h3121});
      cfg_write(8'h1c, 4'hc, {ev_bit[i], 16'h0000});
      cfg_read(8'h1c, 32'h02a0_3121);
    end
    // clearing one sticky bit leaves the other alone
    raise(4'h3, 1'b1);
    raise(4'h4, 1'b1);
    cfg_write(8'h1c, 4'hc, 32'h4000_0000);
    cfg_read(8'h1c, 32'h22a0_3121);
    cfg_write(8'h1c, 4'hc, 32'hffff_0000);
    cfg_read(8'h1c, 32'h02a0_3121);
    // event lands in the very cycle of its clear: the set must win
    fork
      raise(4'h3, 1'b1);
      begin
        @(posedge clk);
        cfg_write(8'h1c, 4'h8, 32'h4000_0000);
      end
    join
    cfg_read(8'h1c, 32'h42a0_3121);
    cfg_write(8'h1c, 4'h8, 32'h4000_0000);
    // enable low: the write and the event are lost, state stands
    ce <= 1'b0;
    cfg_write(8'h1d, 4'h2, 32'h0000_f000);
    raise(4'h5, 1'b1);
    ce <= 1'b1;
    cfg_read(8'h1c, 32'h02a0_3121);
    // second reset in mid-run brings back the reset image and a 000h..fffh window
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    cfg_read(8'h1c, 32'h02a0_0101);
    cfg_read(8'h30, 32'h0000_0000);
    io_probe(32'h0000_0fff, 1'b1);
    summarize();
  end
endmodule : tb_top
